//--- shared/subb_pkg.sv
// Constants and types shared by the subtract datapath and its file memory
package subb_pkg;
	// Operand widths
	localparam int DATA_W      = 8;
	localparam int FADDR_W     = 8;
	localparam int BANK_W      = 4;
	localparam int LIN_ADDR_W  = BANK_W + FADDR_W;

	// Access bank split: low half maps to bank 0, high half to the top bank
	localparam logic [FADDR_W-1:0] ACCESS_SPLIT = 8'h80;
	localparam logic [BANK_W-1:0]  ACCESS_LOW_BANK  = 4'h0;
	localparam logic [BANK_W-1:0]  ACCESS_HIGH_BANK = 4'hf;

	// Flag positions in the status vector
	localparam int FLAG_C  = 0;
	localparam int FLAG_DC = 1;
	localparam int FLAG_Z  = 2;
	localparam int FLAG_OV = 3;
	localparam int FLAG_N  = 4;
	localparam int FLAG_W  = 5;

	// Reset values
	localparam logic [DATA_W-1:0] WORK_RST   = 8'h00;
	localparam logic [BANK_W-1:0] BANK_RST   = 4'h0;
	localparam logic [FLAG_W-1:0] STATUS_RST = 5'h00;

	// Destination bit encodings
	localparam logic DEST_WORK = 1'b0;
	localparam logic DEST_FILE = 1'b1;

	// Subtract forms
	typedef enum logic [1:0] {
		SUBTRACT_WITH_BORROW       = 2'b00,
		SUBTRACT_WORK_FROM_FILE    = 2'b01,
		SUBTRACT_WORK_FROM_LITERAL = 2'b10
	} sub_op_t;

	// Sequencer states
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_FETCH = 2'b01,
		ST_EXEC  = 2'b10
	} seq_state_t;
endpackage

//--- src/file_memory.sv
// Data memory holding the banked file registers, registered read data
`timescale 1ns/1ps
module file_memory #(
	parameter int ADDR_W = 12,
	parameter int DATA_W = 8
) (
	// Clock
	input  wire logic              clk_i,
	// Write port
	input  wire logic              wr_en_i,
	input  wire logic [ADDR_W-1:0] wr_addr_i,
	input  wire logic [DATA_W-1:0] wr_data_i,
	// Read port
	input  wire logic              rd_en_i,
	input  wire logic [ADDR_W-1:0] rd_addr_i,
	output logic      [DATA_W-1:0] rd_data_o
);
	logic [DATA_W-1:0] mem_q [0:(1<<ADDR_W)-1];

	// No reset on the array so it maps onto block RAM
	always_ff @(posedge clk_i) begin
		if (wr_en_i) begin
			mem_q[wr_addr_i] <= wr_data_i;
		end
		if (rd_en_i) begin
			rd_data_o <= mem_q[rd_addr_i];
		end
	end
endmodule

//--- src/subtract_borrow_datapath.sv
// Subtract datapath: working register, bank select, flags and file memory
`timescale 1ns/1ps
module subtract_borrow_datapath #(
	parameter int BANK_W = subb_pkg::BANK_W
) (
	// Clock and reset
	input  wire logic                         clk_i,
	input  wire logic                         rst_i,
	// Instruction request
	input  wire logic                         op_valid_i,
	output logic                              op_ready_o,
	input  wire logic [1:0]                   op_code_i,
	input  wire logic [subb_pkg::FADDR_W-1:0] op_file_i,
	input  wire logic [subb_pkg::DATA_W-1:0]  op_literal_i,
	input  wire logic                         op_dest_i,
	input  wire logic                         op_dest_given_i,
	input  wire logic                         op_bank_i,
	// Completion
	output logic                              done_o,
	output logic [subb_pkg::DATA_W-1:0]       result_o,
	// Core state loads, taken only while idle
	input  wire logic                         work_load_i,
	input  wire logic [subb_pkg::DATA_W-1:0]  work_data_i,
	input  wire logic                         bank_load_i,
	input  wire logic [BANK_W-1:0]            bank_data_i,
	input  wire logic                         status_load_i,
	input  wire logic [subb_pkg::FLAG_W-1:0]  status_data_i,
	// Direct file memory write, taken only while idle
	input  wire logic                         mem_wr_i,
	input  wire logic [BANK_W+subb_pkg::FADDR_W-1:0] mem_addr_i,
	input  wire logic [subb_pkg::DATA_W-1:0]  mem_wdata_i,
	// Core state view
	output logic [subb_pkg::DATA_W-1:0]       working_register_o,
	output logic [BANK_W-1:0]                 bank_select_register_o,
	output logic [subb_pkg::FLAG_W-1:0]       status_o
);
	localparam int LA_W = BANK_W + subb_pkg::FADDR_W;
	localparam int DW   = subb_pkg::DATA_W;

	// Sequencer and captured instruction
	subb_pkg::seq_state_t        state_q, state_d;
	subb_pkg::sub_op_t           op_q, op_d;
	logic [LA_W-1:0]             addr_q, addr_d;
	logic                        dest_q, dest_d;
	logic [DW-1:0]               lit_q, lit_d;

	// Architectural state
	logic [DW-1:0]               working_register_q, working_register_d;
	logic [BANK_W-1:0]           bank_select_register_q, bank_select_register_d;
	logic [subb_pkg::FLAG_W-1:0] status_q, status_d;
	logic [DW-1:0]               result_q, result_d;
	logic                        done_q, done_d;

	// Memory hookup
	logic                        mem_we;
	logic [LA_W-1:0]             mem_waddr;
	logic [DW-1:0]               mem_wdata;
	logic                        mem_re;
	logic [DW-1:0]               mem_rdata;

	// Arithmetic
	logic [DW-1:0]               minuend;
	logic                        borrow_in;
	logic [DW:0]                 diff_full;
	logic [4:0]                  diff_low;
	logic [DW-1:0]               diff;
	logic [BANK_W-1:0]           eff_bank;

	assign op_ready_o             = (state_q == subb_pkg::ST_IDLE);
	assign done_o                 = done_q;
	assign result_o               = result_q;
	assign working_register_o     = working_register_q;
	assign bank_select_register_o = bank_select_register_q;
	assign status_o               = status_q;

	// Bank selection for the file operand
	always_comb begin
		if (op_bank_i) begin
			eff_bank = bank_select_register_q;
		end else if (op_file_i < subb_pkg::ACCESS_SPLIT) begin
			eff_bank = BANK_W'(subb_pkg::ACCESS_LOW_BANK);
		end else begin
			eff_bank = BANK_W'(subb_pkg::ACCESS_HIGH_BANK);
		end
	end

	// Literal form uses the literal as minuend; only the borrow form eats carry
	always_comb begin
		if (op_q == subb_pkg::SUBTRACT_WORK_FROM_LITERAL) begin
			minuend = lit_q;
		end else begin
			minuend = mem_rdata;
		end
		if (op_q == subb_pkg::SUBTRACT_WITH_BORROW) begin
			borrow_in = ~status_q[subb_pkg::FLAG_C];
		end else begin
			borrow_in = 1'b0;
		end
		diff_full = {1'b0, minuend} - {1'b0, working_register_q}
			- {{DW{1'b0}}, borrow_in};
		diff_low  = {1'b0, minuend[3:0]} - {1'b0, working_register_q[3:0]}
			- {4'h0, borrow_in};
		diff      = diff_full[DW-1:0];
	end

	// Sequencer next state
	always_comb begin
		state_d = state_q;
		op_d    = op_q;
		addr_d  = addr_q;
		dest_d  = dest_q;
		lit_d   = lit_q;
		mem_re  = 1'b0;
		unique case (state_q)
			subb_pkg::ST_IDLE: begin
				if (op_valid_i) begin
					op_d   = subb_pkg::sub_op_t'(op_code_i);
					addr_d = {eff_bank, op_file_i};
					lit_d  = op_literal_i;
					mem_re = 1'b1;
					// Literal form always targets the working register
					if (subb_pkg::sub_op_t'(op_code_i) ==
						subb_pkg::SUBTRACT_WORK_FROM_LITERAL) begin
						dest_d = subb_pkg::DEST_WORK;
					end else if (op_dest_given_i) begin
						dest_d = op_dest_i;
					end else begin
						dest_d = subb_pkg::DEST_FILE;
					end
					state_d = subb_pkg::ST_FETCH;
				end
			end
			subb_pkg::ST_FETCH: begin
				state_d = subb_pkg::ST_EXEC;
			end
			subb_pkg::ST_EXEC: begin
				state_d = subb_pkg::ST_IDLE;
			end
			default: begin
				state_d = subb_pkg::ST_IDLE;
			end
		endcase
	end

	// Result, flags and destination write
	always_comb begin
		working_register_d     = working_register_q;
		bank_select_register_d = bank_select_register_q;
		status_d               = status_q;
		result_d               = result_q;
		done_d                 = 1'b0;
		mem_we                 = 1'b0;
		mem_waddr              = mem_addr_i;
		mem_wdata              = mem_wdata_i;
		if (state_q == subb_pkg::ST_IDLE) begin
			if (work_load_i) begin
				working_register_d = work_data_i;
			end
			if (bank_load_i) begin
				bank_select_register_d = bank_data_i;
			end
			if (status_load_i) begin
				status_d = status_data_i;
			end
			mem_we = mem_wr_i;
		end else if (state_q == subb_pkg::ST_FETCH) begin
			result_d = diff;
			done_d   = 1'b1;
			status_d[subb_pkg::FLAG_N]  = diff[DW-1];
			status_d[subb_pkg::FLAG_OV] = (minuend[DW-1] != working_register_q[DW-1])
				&& (diff[DW-1] != minuend[DW-1]);
			status_d[subb_pkg::FLAG_C]  = ~diff_full[DW];
			status_d[subb_pkg::FLAG_DC] = ~diff_low[4];
			status_d[subb_pkg::FLAG_Z]  = (diff == '0);
			if (dest_q == subb_pkg::DEST_WORK) begin
				working_register_d = diff;
			end else begin
				mem_we    = 1'b1;
				mem_waddr = addr_q;
				mem_wdata = diff;
			end
		end
	end

	// Register stage; flags and destination commit at the end of fetch
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q                <= subb_pkg::ST_IDLE;
			op_q                   <= subb_pkg::SUBTRACT_WITH_BORROW;
			addr_q                 <= '0;
			dest_q                 <= subb_pkg::DEST_FILE;
			lit_q                  <= '0;
			working_register_q     <= subb_pkg::WORK_RST;
			bank_select_register_q <= BANK_W'(subb_pkg::BANK_RST);
			status_q               <= subb_pkg::STATUS_RST;
			result_q               <= '0;
			done_q                 <= 1'b0;
		end else begin
			state_q                <= state_d;
			op_q                   <= op_d;
			addr_q                 <= addr_d;
			dest_q                 <= dest_d;
			lit_q                  <= lit_d;
			working_register_q     <= working_register_d;
			bank_select_register_q <= bank_select_register_d;
			status_q               <= status_d;
			result_q               <= result_d;
			done_q                 <= done_d;
		end
	end

	file_memory #(
		.ADDR_W (LA_W),
		.DATA_W (DW)
	) u_file_memory (
		.clk_i     (clk_i),
		.wr_en_i   (mem_we),
		.wr_addr_i (mem_waddr),
		.wr_data_i (mem_wdata),
		.rd_en_i   (mem_re),
		.rd_addr_i (addr_d),
		.rd_data_o (mem_rdata)
	);
endmodule

//--- sim/subb_sva.sv
// Port assertions for the subtract datapath
`timescale 1ns/1ps
module subb_sva (
	// Clock and reset
	input wire logic       clk_i,
	input wire logic       rst_i,
	// Request side
	input wire logic       op_valid_i,
	input wire logic       op_ready_o,
	input wire logic [1:0] op_code_i,
	input wire logic [7:0] op_literal_i,
	input wire logic       op_dest_i,
	input wire logic       op_dest_given_i,
	// Results
	input wire logic       done_o,
	input wire logic [7:0] result_o,
	input wire logic [7:0] working_register_o,
	input wire logic [4:0] status_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire take = op_valid_i && op_ready_o;
	a_done_latency: assert property (take |-> !done_o ##1 !done_o ##1 done_o)
		else $error("done not two cycles after request");
	a_busy_window: assert property (take |=> !op_ready_o ##1 !op_ready_o ##1 op_ready_o)
		else $error("ready window wrong");
	a_done_pulse: assert property (done_o |=> !done_o)
		else $error("done held too long");
	a_zero_flag: assert property (done_o |-> status_o[2] == (result_o == 8'h00))
		else $error("zero flag wrong");
	a_neg_flag: assert property (done_o |-> status_o[4] == result_o[7])
		else $error("negative flag wrong");
	a_dest_work: assert property (take && op_dest_given_i && !op_dest_i |-> ##2
		working_register_o == result_o) else $error("result missing from work");
	a_dest_file: assert property (take && op_code_i != 2'b10
		&& (op_dest_i || !op_dest_given_i) |-> ##2
		working_register_o == $past(working_register_o)) else $error("work changed");
	a_literal_diff: assert property (take && op_code_i == 2'b10 |-> ##2
		result_o == $past(op_literal_i, 2) - $past(working_register_o)) else $error("bad diff");
endmodule
bind subtract_borrow_datapath subb_sva u_sva (.clk_i, .rst_i, .op_valid_i, .op_ready_o, .op_code_i,
	.op_literal_i, .op_dest_i, .op_dest_given_i, .done_o, .result_o, .working_register_o, .status_o);

//--- sim/tb_top.sv
// Self-checking bench for the subtract datapath
`timescale 1ns/1ps
module tb_top;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        op_valid_i = 1'b0, op_dest_i = 1'b0, op_dest_given_i = 1'b0, op_bank_i = 1'b0;
	logic [1:0]  op_code_i = 2'h0;
	logic [7:0]  op_file_i = 8'h00, op_literal_i = 8'h00, work_data_i = 8'h00, mem_wdata_i = 8'h00;
	logic        work_load_i = 1'b0, bank_load_i = 1'b0, status_load_i = 1'b0, mem_wr_i = 1'b0;
	logic [3:0]  bank_data_i = 4'h0;
	logic [4:0]  status_data_i = 5'h00;
	logic [11:0] mem_addr_i = 12'h000;
	logic        op_ready_o, done_o;
	logic [7:0]  result_o, working_register_o;
	logic [3:0]  bank_select_register_o;
	logic [4:0]  status_o;
	int          fail_count = 0, n_tests = 0, cyc = 0;
	subtract_borrow_datapath dut (.clk_i, .rst_i, .op_valid_i, .op_ready_o, .op_code_i, .op_file_i,
		.op_literal_i, .op_dest_i, .op_dest_given_i, .op_bank_i, .done_o, .result_o, .work_load_i,
		.work_data_i, .bank_load_i, .bank_data_i, .status_load_i, .status_data_i, .mem_wr_i,
		.mem_addr_i, .mem_wdata_i, .working_register_o, .bank_select_register_o, .status_o);
	initial forever #2 clk_i = ~clk_i;
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Flags as {N, OV, Z, DC, C}; carries are not-borrow
	function automatic logic [12:0] model(input logic [7:0] a, input logic [7:0] b, input logic bw);
		logic [8:0] d;
		logic [4:0] l;
		d = {1'b0, a} - {1'b0, b} - {8'h00, bw};
		l = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bw};
		return {d[7], (a[7] != b[7]) && (d[7] != a[7]), d[7:0] == 8'h00, ~l[4], ~d[8], d[7:0]};
	endfunction
	task automatic setup(input logic [11:0] a, input logic [7:0] v, input logic [7:0] w,
			input logic [4:0] s, input logic [3:0] b);
		@(posedge clk_i);
		mem_wr_i <= 1'b1;
		mem_addr_i <= a;
		mem_wdata_i <= v;
		work_load_i <= 1'b1;
		work_data_i <= w;
		status_load_i <= 1'b1;
		status_data_i <= s;
		bank_load_i <= 1'b1;
		bank_data_i <= b;
		@(posedge clk_i);
		mem_wr_i <= 1'b0;
		work_load_i <= 1'b0;
		status_load_i <= 1'b0;
		bank_load_i <= 1'b0;
		#1;
		check({4'h0, bank_select_register_o}, {4'h0, b});
	endtask
	task automatic op(input logic [1:0] c, input logic [7:0] f, input logic [7:0] k, input logic d,
			input logic g, input logic b, input logic [12:0] e, input logic [7:0] w);
		@(posedge clk_i);
		op_code_i <= c;
		op_file_i <= f;
		op_literal_i <= k;
		op_dest_i <= d;
		op_dest_given_i <= g;
		op_bank_i <= b;
		op_valid_i <= 1'b1;
		@(posedge clk_i);
		op_valid_i <= 1'b0;
		// Result and flags commit one edge after the taking edge
		@(posedge clk_i);
		#1;
		check({7'h00, done_o}, 8'h01);
		check(result_o, e[7:0]);
		check({3'h0, status_o}, {3'h0, e[12:8]});
		check(working_register_o, w);
	endtask
	task automatic t_borrow();
		setup(12'h020, 8'h19, 8'h0d, 5'h01, 4'h0);
		op(2'b00, 8'h20, 8'h00, 1'b1, 1'b1, 1'b0, model(8'h19, 8'h0d, 1'b0), 8'h0d);
		op(2'b01, 8'h20, 8'h00, 1'b0, 1'b1, 1'b0, model(8'h0c, 8'h0d, 1'b0), 8'hff);
		setup(12'h021, 8'h1b, 8'h1a, 5'h00, 4'h0);
		op(2'b00, 8'h21, 8'h00, 1'b0, 1'b1, 1'b0, model(8'h1b, 8'h1a, 1'b1), 8'h00);
		$display("test borrow done");
	endtask
	task automatic t_default();
		setup(12'h030, 8'h01, 8'h02, 5'h01, 4'h0);
		op(2'b00, 8'h30, 8'h00, 1'b0, 1'b0, 1'b0, model(8'h01, 8'h02, 1'b0), 8'h02);
		op(2'b01, 8'h30, 8'h00, 1'b0, 1'b1, 1'b0, model(8'hff, 8'h02, 1'b0), 8'hfd);
		$display("test default dest done");
	endtask
	task automatic t_bank();
		setup(12'h010, 8'h77, 8'h05, 5'h01, 4'h3);
		setup(12'hf90, 8'h40, 8'h05, 5'h01, 4'h3);
		setup(12'h310, 8'h55, 8'h05, 5'h01, 4'h3);
		op(2'b01, 8'h10, 8'h00, 1'b1, 1'b1, 1'b1, model(8'h55, 8'h05, 1'b0), 8'h05);
		op(2'b01, 8'h10, 8'h00, 1'b1, 1'b1, 1'b0, model(8'h77, 8'h05, 1'b0), 8'h05);
		op(2'b01, 8'h90, 8'h00, 1'b1, 1'b1, 1'b0, model(8'h40, 8'h05, 1'b0), 8'h05);
		$display("test bank done");
	endtask
	task automatic t_literal();
		setup(12'h000, 8'h00, 8'h03, 5'h00, 4'h0);
		op(2'b10, 8'h00, 8'h02, 1'b0, 1'b1, 1'b0, model(8'h02, 8'h03, 1'b0), 8'hff);
		$display("test literal done");
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Whole run needs well under a hundred cycles
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 1000) begin
			$display("[ERR] %0t timeout", $time);
			fail_count++;
			report_and_stop();
		end
	end
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		t_borrow();
		t_default();
		t_bank();
		t_literal();
		report_and_stop();
	end
endmodule
